/* hdl/msac_pkg.sv */
// Overview of operation
// - Result upper eight bits high, two low bits 7:6
// - Lower byte bits 5:0 always read zero
// - Inputs 0/4 to A, 1/5 B, 2/6 C, 3/7 D
// - Reset clears all four result registers
// - Results always readable; lower byte via latch
// - Upper-byte read copies lower byte into latch
// - End flag set after single or full scan
// - Flag cleared by zero write after read-one
// - DMA register access also clears end flag
// - Interrupt request is flag gated by enable bit
// - Start bit starts, reads one, single auto-clears
// - Scan repeats until start written zero; halts
// - Scan begins group first channel, wraps, restarts
// - Mode bit zero single, one scan
// - First conversion 266 or 134 states minimum
// - Later conversions at least 256 or 128 states
// - Single mode channel bits pick input 0-7
// - Scan: bit 2 group, low bits+1 count
// - Trigger enable lets timer pulse set start
// - Triggered start behaves like software start
// - Trigger register bits 6:0 read one
// - Reset loads control/status with zero
// - Reset loads trigger register with 7f
package msac_pkg;

    localparam logic [31:0] ADDR_RES_A_UPPER = 32'hffff8420;
    localparam logic [31:0] ADDR_RES_A_LOWER = 32'hffff8421;
    localparam logic [31:0] ADDR_RES_B_UPPER = 32'hffff8422;
    localparam logic [31:0] ADDR_RES_B_LOWER = 32'hffff8423;
    localparam logic [31:0] ADDR_RES_C_UPPER = 32'hffff8424;
    localparam logic [31:0] ADDR_RES_C_LOWER = 32'hffff8425;
    localparam logic [31:0] ADDR_RES_D_UPPER = 32'hffff8426;
    localparam logic [31:0] ADDR_RES_D_LOWER = 32'hffff8427;
    localparam logic [31:0] ADDR_CSR = 32'hffff8428;
    localparam logic [31:0] ADDR_TRG = 32'hffff8429;

    localparam int RESULT_W = 10;
    localparam int RES_UPPER_LSB = 2;
    localparam int RES_IDX_LSB = 1;
    localparam int RES_IDX_MSB = 2;
    localparam int RES_LOW_SEL_BIT = 0;
    localparam logic [5:0] LOW_PAD = 6'h00;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] TRG_RESET = 8'h7f;
    localparam logic [6:0] TRG_RSVD_ONES = 7'h7f;

    // Conversion lengths in states; one state is one system clock
    localparam logic [8:0] FIRST_LEN_SLOW = 9'h10a;
    localparam logic [8:0] FIRST_LEN_FAST = 9'h086;
    localparam logic [8:0] NEXT_LEN_SLOW = 9'h100;
    localparam logic [8:0] NEXT_LEN_FAST = 9'h080;

    typedef struct packed {
        logic rd;
        logic wr;
        logic dma;
        logic [31:0] addr;
        logic [7:0] wdata;
    } msac_bus_req_t;

    typedef struct packed {
        logic start;
        logic [2:0] chan;
    } msac_core_req_t;

    typedef struct packed {
        logic done;
        logic [RESULT_W-1:0] result;
    } msac_core_rsp_t;

    typedef struct packed {
        logic flag;
        logic ie;
        logic start;
        logic scan;
        logic clock_select;
        logic [2:0] ch;
    } msac_csr_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } msac_state_t;

    typedef enum logic [2:0] {
        RK_NONE = 3'b000,
        RK_UPPER = 3'b001,
        RK_LOWER = 3'b010,
        RK_CSR = 3'b011,
        RK_TRG = 3'b100,
        RK_UNMAP = 3'b101
    } msac_rkind_t;

endpackage

/* hdl/msac_result_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module msac_result_mem
#(
    parameter int W = 10,
    parameter int N = 4,
    parameter int AW = 2
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    import msac_pkg::*;

    typedef struct packed {
        logic [N-1:0][W-1:0] mem;
        logic [W-1:0] q;
    } msac_mem_state_t;

    msac_mem_state_t s_r;
    msac_mem_state_t s_nxt;
    logic [N-1:0][W-1:0] entry_nxt;

    // Per-entry write
    for (genvar g = 0; g < N; g++)
    begin : g_entry
        assign entry_nxt[g] = (i_we && (i_waddr == AW'(g))) ? i_wdata : s_r.mem[g];
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.mem = entry_nxt;
        s_nxt.q = s_r.mem[i_raddr];
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata = s_r.q;

endmodule
`default_nettype wire

/* hdl/msac_top.sv */
`timescale 1ns/10ps
`default_nettype none
module msac_top
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire msac_pkg::msac_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_trig,
    output msac_pkg::msac_core_req_t o_core,
    input wire msac_pkg::msac_core_rsp_t i_core,
    output logic o_conv_end_irq
);
    import msac_pkg::*;

    typedef struct packed {
        msac_state_t st;
        msac_csr_t csr;
        logic trigger_enable;
        logic flag_read;
        logic [8:0] cnt;
        logic first;
        logic [1:0] idx;
        logic done_seen;
        logic [RESULT_W-1:0] res;
        logic [7:0] temp;
        msac_rkind_t p_kind;
        msac_rkind_t r_kind;
        logic [7:0] rdata;
        logic core_start;
        logic [2:0] core_chan;
        logic [11:0] chk_cnt;
        logic [8:0] chk_len;
    } msac_top_state_t;

    localparam msac_top_state_t TOP_RESET = '0;

    msac_top_state_t s_r;
    msac_top_state_t s_nxt;
    msac_rkind_t rkind0;
    logic [31:0] res_off;
    logic [1:0] mem_raddr;
    logic [RESULT_W-1:0] mem_q;
    logic mem_we;
    logic [1:0] mem_waddr;
    logic [RESULT_W-1:0] mem_wdata;
    logic csr_wr;
    logic trg_wr;
    logic dma_acc;
    logic conv_end;
    logic flag_set;
    logic [8:0] len_sel;
    msac_csr_t wcsr;

    assign res_off = i_bus.addr - ADDR_RES_A_UPPER;
    assign mem_raddr = res_off[RES_IDX_MSB:RES_IDX_LSB];
    assign csr_wr = i_bus.wr && (i_bus.addr == ADDR_CSR);
    assign trg_wr = i_bus.wr && (i_bus.addr == ADDR_TRG);
    assign dma_acc = (i_bus.rd || i_bus.wr) && i_bus.dma;
    assign wcsr = msac_csr_t'(i_bus.wdata);

    // Address decode
    always_comb
    begin
        if (!i_bus.rd)
        begin
            rkind0 = RK_NONE;
        end
        else if (i_bus.addr == ADDR_CSR)
        begin
            rkind0 = RK_CSR;
        end
        else if (i_bus.addr == ADDR_TRG)
        begin
            rkind0 = RK_TRG;
        end
        else if ((i_bus.addr >= ADDR_RES_A_UPPER) && (i_bus.addr <= ADDR_RES_D_LOWER))
        begin
            rkind0 = res_off[RES_LOW_SEL_BIT] ? RK_LOWER : RK_UPPER;
        end
        else
        begin
            rkind0 = RK_UNMAP;
        end
    end

    // conversion ends on count expiry and core done
    assign conv_end = (s_r.st == ST_CONV) && (s_r.cnt == '0)
        && (s_r.done_seen || i_core.done) && s_r.csr.start;
    // flag after single or last scanned channel
    assign flag_set = conv_end && (!s_r.csr.scan || (s_r.idx == s_r.csr.ch[1:0]));

    // result written in every conversion end cycle
    assign mem_we = conv_end;
    assign mem_waddr = s_r.core_chan[1:0];
    assign mem_wdata = i_core.done ? i_core.result : s_r.res;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.core_start = 1'b0;
        s_nxt.chk_cnt = s_r.chk_cnt + 12'h001;
        if (i_core.done)
        begin
            s_nxt.res = i_core.result;
        end
        // Read pipeline stage 0
        s_nxt.p_kind = rkind0;
        if ((rkind0 == RK_CSR) && s_r.csr.flag)
        begin
            s_nxt.flag_read = 1'b1;
        end
        // Read pipeline stage 1
        s_nxt.r_kind = s_r.p_kind;
        case (s_r.p_kind)
            RK_UPPER:
            begin
                s_nxt.rdata = mem_q[RESULT_W-1:RES_UPPER_LSB];
                s_nxt.temp = {mem_q[RES_UPPER_LSB-1:0], LOW_PAD};
            end
            RK_LOWER:
            begin
                // low bits from latch, padded zero
                s_nxt.rdata = s_r.temp;
            end
            RK_CSR:
            begin
                s_nxt.rdata = s_r.csr;
            end
            RK_TRG:
            begin
                s_nxt.rdata = {s_r.trigger_enable, TRG_RSVD_ONES};
            end
            RK_UNMAP:
            begin
                s_nxt.rdata = '0;
            end
            default:
            begin
                s_nxt.rdata = s_r.rdata;
            end
        endcase
        // Register writes
        if (csr_wr)
        begin
            s_nxt.csr.ie = wcsr.ie;
            s_nxt.csr.scan = wcsr.scan;
            s_nxt.csr.clock_select = wcsr.clock_select;
            s_nxt.csr.ch = wcsr.ch;
            s_nxt.csr.start = wcsr.start;
            if (!wcsr.flag && s_r.flag_read)
            begin
                s_nxt.csr.flag = 1'b0;
            end
            s_nxt.flag_read = 1'b0;
        end
        if (trg_wr)
        begin
            s_nxt.trigger_enable = i_bus.wdata[7];
        end
        if (dma_acc)
        begin
            s_nxt.csr.flag = 1'b0;
        end
        if (i_trig && s_r.trigger_enable)
        begin
            s_nxt.csr.start = 1'b1;
        end
        // Conversion sequencing
        if (!s_nxt.csr.start)
        begin
            s_nxt.st = ST_IDLE;
        end
        else if (!s_r.csr.start)
        begin
            s_nxt.st = ST_CONV;
            s_nxt.first = 1'b1;
            s_nxt.idx = '0;
        end
        else if (conv_end)
        begin
            if (!s_r.csr.scan)
            begin
                s_nxt.csr.start = 1'b0;
                s_nxt.st = ST_IDLE;
            end
            else
            begin
                s_nxt.first = 1'b0;
                s_nxt.idx = (s_r.idx == s_r.csr.ch[1:0]) ? 2'h0 : s_r.idx + 2'h1;
            end
        end
        else if ((s_r.st == ST_CONV) && (s_r.cnt != '0))
        begin
            s_nxt.cnt = s_r.cnt - 9'h001;
        end
        if ((s_r.st == ST_CONV) && i_core.done)
        begin
            s_nxt.done_seen = 1'b1;
        end
        // length by clock select and first flag
        if (s_nxt.first)
        begin
            len_sel = s_nxt.csr.clock_select ? FIRST_LEN_FAST : FIRST_LEN_SLOW;
        end
        else
        begin
            len_sel = s_nxt.csr.clock_select ? NEXT_LEN_FAST : NEXT_LEN_SLOW;
        end
        // launch a conversion on the core
        if ((s_nxt.st == ST_CONV) && ((s_r.st != ST_CONV) || conv_end))
        begin
            s_nxt.cnt = len_sel - 9'h001;
            s_nxt.chk_len = len_sel - 9'h001;
            s_nxt.chk_cnt = '0;
            s_nxt.done_seen = 1'b0;
            s_nxt.core_start = 1'b1;
            s_nxt.core_chan = s_nxt.csr.scan ? {s_nxt.csr.ch[2], s_nxt.idx} : s_nxt.csr.ch;
        end
        if (flag_set)
        begin
            s_nxt.csr.flag = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            s_r <= TOP_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    msac_result_mem
    #(
        .W(RESULT_W),
        .N(4),
        .AW(2)
    )
    u_mem
    (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_raddr),
        .o_rdata(mem_q)
    );

    assign o_rdata = s_r.rdata;
    assign o_rvalid = (s_r.r_kind != RK_NONE);
    assign o_core.start = s_r.core_start;
    assign o_core.chan = s_r.core_chan;
    assign o_conv_end_irq = s_r.csr.flag && s_r.csr.ie;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    a_irq_follows_flag:
    assert property (flag_set && s_r.csr.ie && !csr_wr && !dma_acc |=> o_conv_end_irq)
        else $error("end interrupt missing after flag set");

    a_irq_masked:
    assert property (!s_r.csr.ie |-> !o_conv_end_irq)
        else $error("interrupt raised while disabled");

    a_flag_rise_cause:
    assert property ($rose(s_r.csr.flag) |-> $past(flag_set))
        else $error("end flag set without conversion end");

    a_flag_fall_cause:
    assert property ($fell(s_r.csr.flag) |->
        $past(csr_wr && !wcsr.flag && s_r.flag_read) || $past(dma_acc))
        else $error("end flag cleared without legal clear");

    a_lower_pad_zero:
    assert property (o_rvalid && (s_r.r_kind == RK_LOWER) |-> (o_rdata[5:0] == LOW_PAD))
        else $error("lower byte reserved bits not zero");

    a_trg_ones:
    assert property (o_rvalid && (s_r.r_kind == RK_TRG) |-> (o_rdata[6:0] == TRG_RSVD_ONES))
        else $error("trigger reserved bits not one");

    a_temp_latch:
    assert property ((s_r.p_kind == RK_UPPER) |=>
        (s_r.temp == {$past(mem_q[RES_UPPER_LSB-1:0]), LOW_PAD}))
        else $error("latch not loaded by upper read");

    a_result_store:
    assert property (flag_set |=> (u_mem.s_r.mem[$past(s_r.core_chan[1:0])] == $past(mem_wdata)))
        else $error("result not stored with end flag");

    a_single_stop:
    assert property (conv_end && !s_r.csr.scan && !i_trig |=>
        !s_r.csr.start && (s_r.st == ST_IDLE))
        else $error("single mode did not stop");

    a_scan_wrap:
    assert property (flag_set && s_r.csr.scan && !csr_wr |=> (s_r.idx == 2'h0) && s_r.core_start)
        else $error("scan did not restart at first channel");

    a_halt_write:
    assert property (csr_wr && !wcsr.start && !(i_trig && s_r.trigger_enable) |=>
        (s_r.st == ST_IDLE) && !s_r.csr.start)
        else $error("zero start write did not halt");

    a_trig_ignored:
    assert property (i_trig && !s_r.trigger_enable && !s_r.csr.start && !csr_wr |=> !s_r.csr.start)
        else $error("disabled trigger started conversion");

    a_conv_length:
    assert property (conv_end |-> (s_r.chk_cnt >= {3'h0, s_r.chk_len}))
        else $error("conversion shorter than selected length");

    a_first_length:
    assert property (s_r.core_start && s_r.first |->
        (s_r.chk_len == (s_r.csr.clock_select ? FIRST_LEN_FAST - 9'h001 : FIRST_LEN_SLOW - 9'h001)))
        else $error("first conversion length wrong");

    a_reset_regs:
    assert property (@(posedge i_clk_sys) disable iff (1'b0)
        i_rst |=> (s_r.csr == CSR_RESET) && ({s_r.trigger_enable, TRG_RSVD_ONES} == TRG_RESET))
        else $error("control registers not at reset value");

    c_single_end: cover property (conv_end && !s_r.csr.scan);
    c_scan_wrap: cover property (flag_set && s_r.csr.scan && (s_r.csr.ch[1:0] == 2'h3));
    c_trig_start: cover property (i_trig && s_r.trigger_enable && !s_r.csr.start);
    c_dma_clear: cover property (dma_acc && s_r.csr.flag);

endmodule
`default_nettype wire

/* sim/msac_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module msac_core_model
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [8:0] i_delay,
    input wire msac_pkg::msac_core_req_t i_req,
    output var msac_pkg::msac_core_rsp_t o_rsp
);
    import msac_pkg::*;
    logic busy;
    logic [8:0] cnt;
    logic [2:0] chan;
    always_ff @(posedge i_clk_sys)
    begin
        o_rsp.done <= 1'b0;
        o_rsp.result <= ~o_rsp.result;
        if (i_rst)
        begin
            busy <= 1'b0;
            cnt <= 9'h000;
            chan <= 3'h0;
            o_rsp.result <= 10'h155;
        end
        else if (busy)
        begin
            if (cnt == 9'h000)
            begin
                busy <= 1'b0;
                o_rsp.done <= 1'b1;
                o_rsp.result <= {chan, ~chan, chan, 1'b1};
            end
            else
            begin
                cnt <= cnt - 9'h001;
            end
        end
        else if (i_req.start)
        begin
            busy <= 1'b1;
            cnt <= i_delay;
            chan <= i_req.chan;
        end
    end
endmodule
`default_nettype wire

/* sim/msac_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module msac_top_tb_top;
    import msac_pkg::*;
    typedef struct {logic [31:0] a; logic [7:0] e;} msac_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    msac_bus_req_t bus = '0;
    logic trig = 1'b0;
    logic [8:0] delay = 9'h002;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    msac_core_req_t core_req;
    msac_core_rsp_t core_rsp;
    int error_cnt = 0;
    int num_checks = 0;
    int starts = 0;
    int n;
    int s0;
    longint t0;
    logic [7:0] v;
    msac_row_t rows [12] = '{
        '{ADDR_RES_A_UPPER, 8'h00}, '{ADDR_RES_A_LOWER, 8'h00},
        '{ADDR_RES_B_UPPER, 8'h00}, '{ADDR_RES_B_LOWER, 8'h00},
        '{ADDR_RES_C_UPPER, 8'h00}, '{ADDR_RES_C_LOWER, 8'h00},
        '{ADDR_RES_D_UPPER, 8'h00}, '{ADDR_RES_D_LOWER, 8'h00},
        '{ADDR_CSR, 8'h00}, '{ADDR_TRG, 8'h7f},
        '{32'hffff842a, 8'h00}, '{32'hffff8430, 8'h00}};

    always #12.5 clk = ~clk;
    always @(negedge clk)
        if (core_req.start === 1'b1)
            starts++;

    msac_top msac_top_i (.i_clk_sys(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
        .o_rvalid(rvalid), .i_trig(trig), .o_core(core_req), .i_core(core_rsp),
        .o_conv_end_irq(irq));
    msac_core_model msac_core_model_i (.i_clk_sys(clk), .i_rst(rst), .i_delay(delay),
        .i_req(core_req), .o_rsp(core_rsp));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(negedge clk);
        bus.wr = 1'b1;
        bus.addr = a;
        bus.wdata = d;
        @(negedge clk);
        bus.wr = 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic dm, output logic [7:0] d);
        d = 8'hxx;
        @(negedge clk);
        bus.rd = 1'b1;
        bus.dma = dm;
        bus.addr = a;
        @(negedge clk);
        bus.rd = 1'b0;
        bus.dma = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            if (rvalid === 1'b1)
            begin
                d = rdata;
                break;
            end
        end
    endtask

    task automatic chk_rows;
        for (int i = 0; i < 12; i++)
        begin
            rd(rows[i].a, 1'b0, v);
            chk(v, rows[i].e);
        end
    endtask

    task automatic chk_res(input logic [2:0] c);
        logic [9:0] e;
        e = {c, ~c, c, 1'b1};
        rd(ADDR_RES_A_UPPER + 32'(2 * c[1:0]), 1'b0, v);
        chk(v, e[9:2]);
        rd(ADDR_RES_A_LOWER + 32'(2 * c[1:0]), 1'b0, v);
        chk(v, {e[1:0], 6'h00});
    endtask

    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 1000)
        begin
            @(negedge clk);
            c++;
        end
    endtask

    task automatic pulse_trig;
        @(negedge clk);
        trig = 1'b1;
        @(negedge clk);
        trig = 1'b0;
    endtask

    task automatic results;
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #(8000 * 25);
        error_cnt++;
        $display("watchdog expired");
        results;
    end

    initial
    begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk_rows;
        $display("test reset_values done");
        wr(ADDR_CSR, 8'h65);
        wait_irq(n);
        chk(8'(n >= 255 && n <= 270), 8'h01);
        rd(ADDR_CSR, 1'b0, v);
        chk(v, 8'hc5);
        chk_res(3'h5);
        wr(ADDR_CSR, 8'hc5);
        rd(ADDR_CSR, 1'b0, v);
        chk(v, 8'hc5);
        wr(ADDR_CSR, 8'h45);
        rd(ADDR_CSR, 1'b0, v);
        chk(v, 8'h45);
        chk({7'h00, irq}, 8'h00);
        $display("test single done");
        wr(ADDR_CSR, 8'h76);
        wait_irq(n);
        chk(8'(n >= 770 && n <= 790), 8'h01);
        chk_res(3'h4);
        chk_res(3'h6);
        wr(ADDR_CSR, 8'h56);
        s0 = starts;
        repeat (600) @(negedge clk);
        chk(8'(starts - s0), 8'h00);
        rd(ADDR_CSR, 1'b0, v);
        chk(v, 8'hd6);
        rd(ADDR_RES_A_UPPER, 1'b1, v);
        rd(ADDR_CSR, 1'b0, v);
        chk(v, 8'h56);
        chk({7'h00, irq}, 8'h00);
        $display("test scan done");
        wr(ADDR_CSR, 8'h03);
        wr(ADDR_TRG, 8'h7f);
        s0 = starts;
        pulse_trig;
        repeat (300) @(negedge clk);
        chk(8'(starts - s0), 8'h00);
        wr(ADDR_TRG, 8'hff);
        rd(ADDR_TRG, 1'b0, v);
        chk(v, 8'hff);
        delay = 9'h12c;
        t0 = $time;
        pulse_trig;
        rd(ADDR_CSR, 1'b0, v);
        chk(v, 8'h23);
        for (int k = 0; k < 200 && v[7] !== 1'b1; k++)
            rd(ADDR_CSR, 1'b0, v);
        chk(v, 8'h83);
        chk(8'(($time - t0) / 25 >= 300), 8'h01);
        chk({7'h00, irq}, 8'h00);
        chk_res(3'h3);
        $display("test trigger done");
        delay = 9'h002;
        wr(ADDR_CSR, 8'h26);
        repeat (50) @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk_rows;
        $display("test mid_reset done");
        results;
    end
endmodule
`default_nettype wire
